//--- msp_pkg.sv
// Constants and types of the motor stop and speed pulse control.
package msp_pkg;
  localparam int MSP_AW = 6;
  localparam logic [MSP_AW-1:0] MSP_CTRL_OFS = 6'h00;
  localparam logic [MSP_AW-1:0] MSP_CMD_OFS = 6'h04;
  localparam logic [MSP_AW-1:0] MSP_SPEED_OFS = 6'h08;
  localparam logic [MSP_AW-1:0] MSP_HOLD_OFS = 6'h0c;
  localparam logic [MSP_AW-1:0] MSP_PULSE_OFS = 6'h10;
  localparam logic [MSP_AW-1:0] MSP_CAP_OFS = 6'h14;
  localparam logic [MSP_AW-1:0] MSP_STAT_OFS = 6'h18;
  localparam logic [MSP_AW-1:0] MSP_CLAMP_OFS = 6'h1c;
  localparam logic [MSP_AW-1:0] MSP_SETP_OFS = 6'h20;
  localparam logic [31:0] MSP_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MSP_SPEED_RST = 32'h0000_0000;
  localparam logic [31:0] MSP_HOLD_RST = 32'h0000_0001;
  localparam logic [31:0] MSP_PULSE_RST = 32'h0000_0001;
  localparam logic [31:0] MSP_CAP_RST = 32'h0000_ffff;
  localparam logic [31:0] MSP_SETP_RST = 32'h0000_0000;
  localparam int MSP_CMD_STOP_BIT = 0;
  localparam int MSP_CMD_START_BIT = 1;
  localparam logic [2:0] MSP_STOP_COAST = 3'h0;
  localparam logic [2:0] MSP_STOP_BRAKE = 3'h2;
  localparam logic [2:0] MSP_STOP_SPIN = 3'h4;
  localparam logic [1:0] MSP_OL_FOLLOW = 2'h0;
  localparam logic [1:0] MSP_OL_HIGH = 2'h1;
  localparam logic [1:0] MSP_OL_FIRST = 2'h2;
  localparam logic [1:0] MSP_LVL_LOW = 2'h0;
  localparam logic [1:0] MSP_LVL_HIGH = 2'h1;
  localparam int MSP_HYST_UP_PCT = 105;
  localparam int MSP_HYST_DN_PCT = 95;
  localparam int MSP_BRAKE_TICK_US = 1000;
  localparam int MSP_CLK_MHZ = 100;
  localparam int MSP_BRAKE_TICK_CYC = MSP_BRAKE_TICK_US * MSP_CLK_MHZ;
  localparam int MSP_DIV_MAX = 15;

  typedef enum logic [2:0] {
    MSP_ST_HIZ = 3'b000,
    MSP_ST_RUN = 3'b001,
    MSP_ST_RAMP_BRK = 3'b010,
    MSP_ST_HOLD_BRK = 3'b011,
    MSP_ST_RAMP_SPIN = 3'b100,
    MSP_ST_PIN_RAMP = 3'b101,
    MSP_ST_PIN_BRK = 3'b110
  } msp_state_t;

  typedef enum logic [1:0] {
    MSP_STAGE_HIZ = 2'b00,
    MSP_STAGE_DRIVE = 2'b01,
    MSP_STAGE_LOWSIDE = 2'b10
  } msp_stage_t;

  typedef struct packed {
    logic [2:0] stop_method_select;
    logic speed_pulse_hold_policy;
    logic [1:0] open_loop_pulse_select;
    logic [1:0] pulse_fault_level;
    logic [1:0] pulse_idle_level;
    logic supply_current_cap_on;
    logic active_brake_en;
  } msp_cfg_t;

  typedef struct packed {
    logic [15:0] motor_speed;
    logic [15:0] backemf_level;
    logic [15:0] supply_current_est;
    logic elec_half_tick;
    logic open_loop;
    logic closed_loop;
    logic fault_active;
    logic wake_event;
    logic speed_mode;
  } msp_core_t;

  typedef struct packed {
    msp_stage_t stage_mode;
    logic [2:0] lowside_on;
    logic [2:0] highside_on;
    logic ramp_req;
    logic [15:0] ramp_target;
  } msp_stage_out_t;
endpackage : msp_pkg

//--- msp_ctl.sv
// Stop sequencer, speed pulse divider and supply current limiter.
`timescale 1ns/10ps
`default_nettype none
module msp_ctl #(
  parameter int BRAKE_TICK_CYC = msp_pkg::MSP_BRAKE_TICK_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM register slave.
  input wire logic [msp_pkg::MSP_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Control core status.
  input wire msp_pkg::msp_core_t core_in,
  // External brake request pin.
  input wire logic brake_req,
  // Power stage and ramp command.
  output msp_pkg::msp_stage_out_t stage_out,
  // Speed pulse pin.
  output logic speed_pulse_out,
  // Limited references.
  output logic [15:0] clamped_speed_target,
  output logic [15:0] clamped_current_target,
  output logic supply_cap_active_flag
);
  import msp_pkg::*;

  if (BRAKE_TICK_CYC < 1) begin : g_bad_tick
    $error("BRAKE_TICK_CYC must be at least one");
  end

  function automatic logic [15:0] pct_of(input logic [15:0] x, input int pct);
    logic [31:0] prod;
    prod = 32'(x) * 32'(pct) / 32'd100;
    pct_of = (prod > 32'h0000_ffff) ? 16'hffff : prod[15:0];
  endfunction : pct_of

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction : be_merge

  logic ack_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] speed_reg;
  logic [31:0] hold_reg;
  logic [31:0] pulse_reg;
  logic [31:0] cap_reg;
  logic [31:0] setp_reg;
  logic [31:0] rdata_reg;
  logic stop_cmd;
  logic start_cmd;
  logic wr_take;
  msp_cfg_t cfg;
  msp_state_t state_reg;
  msp_state_t state_next;
  logic [31:0] tick_cnt_reg;
  logic [15:0] hold_cnt_reg;
  logic [15:0] brake_entry_speed;
  logic [15:0] spin_down_speed;
  logic [15:0] brake_hold_time;
  logic [3:0] pulse_divider;
  logic [15:0] pulse_backemf_floor;
  logic [15:0] supply_current_cap;
  logic [3:0] div_cnt_reg;
  logic div_out_reg;
  logic first_start_reg;
  logic pulse_active;
  logic pulse_next;
  logic driving;
  logic cap_engaged_reg;
  logic [15:0] clamp_reg;
  logic [15:0] active_setp;
  logic limiter_on;

  assign cfg = {ctrl_reg[2:0], ctrl_reg[3], ctrl_reg[5:4], ctrl_reg[7:6], ctrl_reg[9:8],
                ctrl_reg[10], ctrl_reg[11]};
  assign brake_entry_speed = speed_reg[15:0];
  assign spin_down_speed = speed_reg[31:16];
  assign brake_hold_time = hold_reg[15:0];
  assign pulse_divider = pulse_reg[3:0];
  assign pulse_backemf_floor = pulse_reg[31:16];
  assign supply_current_cap = cap_reg[15:0];

  // Every access waits exactly one cycle so read data can come from a flip-flop.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_take = avs_write & ack_reg;
  assign avs_readdata = rdata_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= MSP_CTRL_RST;
      speed_reg <= MSP_SPEED_RST;
      hold_reg <= MSP_HOLD_RST;
      pulse_reg <= MSP_PULSE_RST;
      cap_reg <= MSP_CAP_RST;
      setp_reg <= MSP_SETP_RST;
    end else if (wr_take) begin
      if (avs_address == MSP_CTRL_OFS) begin
        ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable) & 32'h0000_0fff;
      end else if (avs_address == MSP_SPEED_OFS) begin
        speed_reg <= be_merge(speed_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == MSP_HOLD_OFS) begin
        hold_reg <= be_merge(hold_reg, avs_writedata, avs_byteenable) & 32'h0000_ffff;
      end else if (avs_address == MSP_PULSE_OFS) begin
        pulse_reg <= be_merge(pulse_reg, avs_writedata, avs_byteenable) & 32'hffff_000f;
      end else if (avs_address == MSP_CAP_OFS) begin
        cap_reg <= be_merge(cap_reg, avs_writedata, avs_byteenable) & 32'h0000_ffff;
      end else if (avs_address == MSP_SETP_OFS) begin
        setp_reg <= be_merge(setp_reg, avs_writedata, avs_byteenable);
      end
    end
  end

  assign stop_cmd = wr_take && (avs_address == MSP_CMD_OFS) && avs_byteenable[0]
                    && avs_writedata[MSP_CMD_STOP_BIT];
  assign start_cmd = wr_take && (avs_address == MSP_CMD_OFS) && avs_byteenable[0]
                     && avs_writedata[MSP_CMD_START_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      if (avs_address == MSP_CTRL_OFS) begin
        rdata_reg <= ctrl_reg;
      end else if (avs_address == MSP_SPEED_OFS) begin
        rdata_reg <= speed_reg;
      end else if (avs_address == MSP_HOLD_OFS) begin
        rdata_reg <= hold_reg;
      end else if (avs_address == MSP_PULSE_OFS) begin
        rdata_reg <= pulse_reg;
      end else if (avs_address == MSP_CAP_OFS) begin
        rdata_reg <= cap_reg;
      end else if (avs_address == MSP_STAT_OFS) begin
        rdata_reg <= {27'h000_0000, first_start_reg, supply_cap_active_flag, state_reg};
      end else if (avs_address == MSP_CLAMP_OFS) begin
        rdata_reg <= {clamped_current_target, clamped_speed_target};
      end else if (avs_address == MSP_SETP_OFS) begin
        rdata_reg <= setp_reg;
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // The brake pin outranks any stop command arriving in the same cycle.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MSP_ST_HIZ: begin
        if (brake_req) begin
          state_next = MSP_ST_PIN_RAMP;
        end else if (start_cmd) begin
          state_next = MSP_ST_RUN;
        end
      end
      MSP_ST_RUN: begin
        if (brake_req) begin
          state_next = MSP_ST_PIN_RAMP;
        end else if (stop_cmd) begin
          if (cfg.stop_method_select == MSP_STOP_BRAKE) begin
            if (core_in.motor_speed < brake_entry_speed) begin
              state_next = MSP_ST_HOLD_BRK;
            end else begin
              state_next = MSP_ST_RAMP_BRK;
            end
          end else if (cfg.stop_method_select == MSP_STOP_SPIN) begin
            state_next = MSP_ST_RAMP_SPIN;
          end else begin
            state_next = MSP_ST_HIZ;
          end
        end
      end
      MSP_ST_RAMP_BRK: begin
        if (brake_req) begin
          state_next = MSP_ST_PIN_RAMP;
        end else if (core_in.motor_speed <= brake_entry_speed) begin
          state_next = MSP_ST_HOLD_BRK;
        end
      end
      MSP_ST_HOLD_BRK: begin
        if (brake_req) begin
          state_next = MSP_ST_PIN_BRK;
        end else if (hold_cnt_reg >= brake_hold_time) begin
          state_next = MSP_ST_HIZ;
        end
      end
      MSP_ST_RAMP_SPIN: begin
        if (brake_req) begin
          state_next = MSP_ST_PIN_RAMP;
        end else if (core_in.motor_speed <= spin_down_speed) begin
          state_next = MSP_ST_HIZ;
        end
      end
      MSP_ST_PIN_RAMP: begin
        if (!brake_req) begin
          state_next = MSP_ST_HIZ;
        end else if (core_in.motor_speed <= brake_entry_speed) begin
          state_next = MSP_ST_PIN_BRK;
        end
      end
      MSP_ST_PIN_BRK: begin
        if (!brake_req) begin
          state_next = MSP_ST_HIZ;
        end
      end
      default: begin
        state_next = MSP_ST_HIZ;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= MSP_ST_HIZ;
    end else begin
      state_reg <= state_next;
    end
  end

  // Hold time counts in coarse ticks so a 16-bit field spans long brakes.
  always_ff @(posedge clk) begin
    if (srst || state_reg != MSP_ST_HOLD_BRK) begin
      tick_cnt_reg <= 32'h0000_0000;
      hold_cnt_reg <= 16'h0000;
    end else if (tick_cnt_reg >= 32'(BRAKE_TICK_CYC - 1)) begin
      tick_cnt_reg <= 32'h0000_0000;
      if (hold_cnt_reg != 16'hffff) begin
        hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      end
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage_out <= '0;
    end else begin
      stage_out.ramp_req <= 1'b0;
      stage_out.ramp_target <= 16'h0000;
      stage_out.highside_on <= 3'b000;
      stage_out.lowside_on <= 3'b000;
      stage_out.stage_mode <= MSP_STAGE_HIZ;
      case (state_next)
        MSP_ST_RUN: begin
          stage_out.stage_mode <= MSP_STAGE_DRIVE;
        end
        MSP_ST_RAMP_BRK, MSP_ST_PIN_RAMP: begin
          stage_out.stage_mode <= MSP_STAGE_DRIVE;
          stage_out.ramp_req <= 1'b1;
          stage_out.ramp_target <= brake_entry_speed;
        end
        MSP_ST_RAMP_SPIN: begin
          stage_out.stage_mode <= MSP_STAGE_DRIVE;
          stage_out.ramp_req <= 1'b1;
          stage_out.ramp_target <= spin_down_speed;
        end
        MSP_ST_HOLD_BRK, MSP_ST_PIN_BRK: begin
          stage_out.stage_mode <= MSP_STAGE_LOWSIDE;
          stage_out.lowside_on <= 3'b111;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_reg <= 4'h0;
      div_out_reg <= 1'b0;
    end else if (core_in.elec_half_tick) begin
      if (div_cnt_reg + 4'h1 >= ((pulse_divider == 4'h0) ? 4'h1 : pulse_divider)) begin
        div_cnt_reg <= 4'h0;
        div_out_reg <= ~div_out_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
    end
  end

  // A wake event sets the flag and wins over the clear by a finished start-up.
  always_ff @(posedge clk) begin
    if (srst) begin
      first_start_reg <= 1'b1;
    end else if (core_in.wake_event) begin
      first_start_reg <= 1'b1;
    end else if (core_in.closed_loop) begin
      first_start_reg <= 1'b0;
    end
  end

  assign driving = (state_reg == MSP_ST_RUN) || (state_reg == MSP_ST_RAMP_BRK)
                   || (state_reg == MSP_ST_RAMP_SPIN) || (state_reg == MSP_ST_PIN_RAMP);
  assign pulse_active = driving || (cfg.speed_pulse_hold_policy
                        && core_in.backemf_level >= pulse_backemf_floor);

  always_comb begin
    pulse_next = div_out_reg;
    if (core_in.fault_active) begin
      pulse_next = (cfg.pulse_fault_level == MSP_LVL_LOW) ? 1'b0 :
                   (cfg.pulse_fault_level == MSP_LVL_HIGH) ? 1'b1 : div_out_reg;
    end else if (!pulse_active) begin
      pulse_next = (cfg.pulse_idle_level == MSP_LVL_LOW) ? 1'b0 :
                   (cfg.pulse_idle_level == MSP_LVL_HIGH) ? 1'b1 : div_out_reg;
    end else if (core_in.open_loop) begin
      if (cfg.open_loop_pulse_select == MSP_OL_HIGH) begin
        pulse_next = 1'b1;
      end else if (cfg.open_loop_pulse_select == MSP_OL_FIRST) begin
        pulse_next = first_start_reg ? div_out_reg : 1'b1;
      end else begin
        pulse_next = div_out_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      speed_pulse_out <= 1'b0;
    end else begin
      speed_pulse_out <= pulse_next;
    end
  end

  // The clamp walks one step per cycle; slow, and only the hysteresis thresholds divide, by 100.
  assign limiter_on = cfg.supply_current_cap_on && !cfg.active_brake_en;
  assign active_setp = core_in.speed_mode ? setp_reg[15:0] : setp_reg[31:16];

  always_ff @(posedge clk) begin
    if (srst || !limiter_on) begin
      cap_engaged_reg <= 1'b0;
      clamp_reg <= 16'hffff;
    end else begin
      if (!cap_engaged_reg) begin
        clamp_reg <= active_setp;
        if (core_in.supply_current_est > pct_of(supply_current_cap, MSP_HYST_UP_PCT)) begin
          cap_engaged_reg <= 1'b1;
        end
      end else if (core_in.supply_current_est > supply_current_cap) begin
        if (clamp_reg != 16'h0000) begin
          clamp_reg <= clamp_reg - 16'h0001;
        end
      end else if (core_in.supply_current_est < pct_of(supply_current_cap, MSP_HYST_DN_PCT)) begin
        if (clamp_reg >= active_setp) begin
          cap_engaged_reg <= 1'b0;
        end else begin
          clamp_reg <= clamp_reg + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clamped_speed_target <= 16'h0000;
      clamped_current_target <= 16'h0000;
      supply_cap_active_flag <= 1'b0;
    end else begin
      clamped_speed_target <= setp_reg[15:0];
      clamped_current_target <= setp_reg[31:16];
      supply_cap_active_flag <= cap_engaged_reg && (clamp_reg < active_setp);
      if (cap_engaged_reg && clamp_reg < active_setp) begin
        if (core_in.speed_mode) begin
          clamped_speed_target <= clamp_reg;
        end else begin
          clamped_current_target <= clamp_reg;
        end
      end
    end
  end
endmodule : msp_ctl
`default_nettype wire

//--- msp_ctl_sva.sv
// Port-level assertions of the motor stop and speed pulse control.
`timescale 1ns/10ps
`default_nettype none
module msp_ctl_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register bus.
  input wire logic [msp_pkg::MSP_AW-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Core status and brake pin.
  input wire msp_pkg::msp_core_t core_in,
  input wire logic brake_req,
  // Outputs of the block.
  input wire msp_pkg::msp_stage_out_t stage_out,
  input wire logic speed_pulse_out,
  input wire logic [15:0] clamped_speed_target,
  input wire logic [15:0] clamped_current_target,
  input wire logic supply_cap_active_flag
);
  import msp_pkg::*;
  logic [11:0] ctl_q, ctl_d;
  logic stop_acc, run_st;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  assign stop_acc = avs_write && !avs_waitrequest && avs_address == MSP_CMD_OFS
    && avs_writedata[MSP_CMD_STOP_BIT] && avs_byteenable[0];
  assign run_st = stage_out.stage_mode == MSP_STAGE_DRIVE && !stage_out.ramp_req;
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q <= 12'h000;
    end else if (avs_write && !avs_waitrequest && avs_address == MSP_CTRL_OFS) begin
      if (avs_byteenable[0]) ctl_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) ctl_q[11:8] <= avs_writedata[11:8];
    end
  end
  always_ff @(posedge clk) ctl_d <= ctl_q;
  a_hiz_all_off: assert property (stage_out.stage_mode == MSP_STAGE_HIZ |->
    stage_out.lowside_on == 3'h0 && stage_out.highside_on == 3'h0)
    else $error("Transistor on in Hi-Z.");
  a_lowside_all_on: assert property (stage_out.stage_mode == MSP_STAGE_LOWSIDE |->
    stage_out.lowside_on == 3'h7 && stage_out.highside_on == 3'h0)
    else $error("Low-side pattern wrong.");
  a_coast_stop: assert property (stop_acc && run_st && !brake_req
    && ctl_q[2:0] != MSP_STOP_BRAKE && ctl_q[2:0] != MSP_STOP_SPIN
    |-> ##[1:2] stage_out.stage_mode == MSP_STAGE_HIZ)
    else $error("Coast stop missed Hi-Z.");
  a_brake_stop: assert property (stop_acc && run_st && !brake_req
    && ctl_q[2:0] == MSP_STOP_BRAKE
    |-> ##[1:2] (stage_out.ramp_req || stage_out.stage_mode == MSP_STAGE_LOWSIDE))
    else $error("Brake stop not begun.");
  a_pin_brake_hold: assert property (stage_out.stage_mode == MSP_STAGE_LOWSIDE
    && brake_req ##1 brake_req |-> stage_out.stage_mode == MSP_STAGE_LOWSIDE)
    else $error("Pin brake left early.");
  a_idle_level: assert property ((stage_out.stage_mode == MSP_STAGE_HIZ && !ctl_q[3]
    && !core_in.fault_active && !ctl_q[9] && ctl_d == ctl_q)[*3]
    |-> speed_pulse_out == ctl_q[8])
    else $error("Idle pulse level wrong.");
  a_fault_level: assert property ((core_in.fault_active && !ctl_q[7]
    && ctl_d == ctl_q)[*3] |-> speed_pulse_out == ctl_q[6])
    else $error("Fault pulse level wrong.");
  a_limit_off: assert property ((ctl_q[11] || !ctl_q[10])[*4]
    |-> !supply_cap_active_flag)
    else $error("Limiter flag while off.");
  a_open_high: assert property ((core_in.open_loop && !core_in.closed_loop && run_st
    && !core_in.fault_active && ctl_q[5:4] == MSP_OL_HIGH && ctl_d == ctl_q)[*3]
    |-> speed_pulse_out)
    else $error("Open-loop pulse not high.");
endmodule : msp_ctl_chk
bind msp_ctl msp_ctl_chk chk (.clk(clk), .srst(srst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .core_in(core_in), .brake_req(brake_req),
  .stage_out(stage_out), .speed_pulse_out(speed_pulse_out),
  .clamped_speed_target(clamped_speed_target),
  .clamped_current_target(clamped_current_target),
  .supply_cap_active_flag(supply_cap_active_flag));
`default_nettype wire

//--- msp_stage_model.sv
// Behavioural motor and power stage answering ramp commands; brake commands leave the speed unchanged.
`timescale 1ns/10ps
`default_nettype none
module msp_stage_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Commands from the block and values from the bench.
  input wire msp_pkg::msp_stage_out_t stage_out,
  input wire msp_pkg::msp_core_t tb_core,
  input wire logic spd_load,
  // Status seen by the block.
  output msp_pkg::msp_core_t core_in
);
  import msp_pkg::*;
  logic [15:0] spd_reg;
  logic [2:0] ph_reg;
  // The rotor slows only under a ramp or a bench speed load, and a ramp settles exactly on its target, staying in step.
  always_ff @(posedge clk) begin
    if (srst) begin
      spd_reg <= 16'h0;
    end else if (spd_load) begin
      spd_reg <= tb_core.motor_speed;
    end else if (stage_out.ramp_req && spd_reg > stage_out.ramp_target) begin
      spd_reg <= (spd_reg > stage_out.ramp_target + 16'h10) ? spd_reg - 16'h10
        : stage_out.ramp_target;
    end
  end
  always_ff @(posedge clk) begin
    ph_reg <= srst ? 3'h0 : ph_reg + 3'h1;
  end
  always_comb begin
    core_in = tb_core;
    core_in.motor_speed = spd_reg;
    core_in.backemf_level = spd_reg;
    core_in.elec_half_tick = ph_reg == 3'h0 && spd_reg != 16'h0;
  end
endmodule : msp_stage_model
`default_nettype wire

//--- test_motor_stop_speed_pulse_ctl.sv
// Self-checking bench of the motor stop and speed pulse control.
`timescale 1ns/10ps
`default_nettype none
module test_motor_stop_speed_pulse_ctl;
  import msp_pkg::*;
  localparam int TICK = 4;
  logic clk, srst, rd, wr, wt, spd_load, brake_req, spo, flag;
  logic [MSP_AW-1:0] adr;
  logic [31:0] wd, rdat, rv;
  logic [15:0] cst, cct;
  msp_core_t tb_core, core_in;
  msp_stage_out_t so;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  msp_ctl #(.BRAKE_TICK_CYC(TICK)) dut (.clk(clk), .srst(srst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wt), .core_in(core_in), .brake_req(brake_req),
    .stage_out(so), .speed_pulse_out(spo), .clamped_speed_target(cst),
    .clamped_current_target(cct), .supply_cap_active_flag(flag));
  msp_stage_model motor (.clk(clk), .srst(srst), .stage_out(so), .tb_core(tb_core),
    .spd_load(spd_load), .core_in(core_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // One idle edge precedes each request, so release and next request never share a step.
  task automatic bus(input logic w, input logic [MSP_AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wt !== 1'b0);
    @(posedge clk);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic spd(input logic [15:0] s);
    @(posedge clk);
    tb_core.motor_speed <= s;
    spd_load <= 1'b1;
    @(posedge clk);
    spd_load <= 1'b0;
  endtask : spd
  task automatic wait_mode(input msp_stage_t m, output int n);
    n = 0;
    while (so.stage_mode !== m && n < 2000) begin
      @(negedge clk);
      n++;
    end
    cmp("stage mode", m, so.stage_mode);
  endtask : wait_mode
  task automatic go(input logic [15:0] s);
    bus(1'b1, MSP_CMD_OFS, 32'h2);
    spd(s);
  endtask : go
  task automatic halt;
    int n;
    bus(1'b1, MSP_CMD_OFS, 32'h1);
    wait_mode(MSP_STAGE_HIZ, n);
  endtask : halt
  task automatic edges(input int len, output int n, output int per);
    logic p;
    int last;
    {n, per, last} = '0;
    p = spo;
    for (int i = 0; i < len; i++) begin
      @(negedge clk);
      if (spo === 1'b1 && p === 1'b0) begin
        n++;
        per = i - last;
        last = i;
      end
      p = spo;
    end
  endtask : edges
  task automatic t_regs;
    bus(1'b0, MSP_HOLD_OFS, 32'h0);
    cmp("hold reset", MSP_HOLD_RST, rv);
    bus(1'b0, MSP_CAP_OFS, 32'h0);
    cmp("cap reset", MSP_CAP_RST, rv);
    bus(1'b1, 6'h3c, 32'hffff_ffff);
    bus(1'b0, 6'h3c, 32'h0);
    cmp("unmapped", 32'h0, rv);
  endtask : t_regs
  task automatic t_stops;
    int n;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    foreach (codes[i]) begin
      bus(1'b1, MSP_CTRL_OFS, {29'h0, codes[i]});
      go(16'h03e8);
      bus(1'b1, MSP_CMD_OFS, 32'h1);
      repeat (2) @(negedge clk);
      cmp("coast", MSP_STAGE_HIZ, so.stage_mode);
    end
    bus(1'b1, MSP_SPEED_OFS, 32'h012c_0064);
    bus(1'b1, MSP_HOLD_OFS, 32'h3);
    bus(1'b1, MSP_CTRL_OFS, 32'h2);
    go(16'h03e8);
    bus(1'b1, MSP_CMD_OFS, 32'h1);
    repeat (2) @(negedge clk);
    cmp("brake ramp target", 32'h64, so.ramp_target);
    wait_mode(MSP_STAGE_LOWSIDE, n);
    cmp("brake entry speed", 32'h64, core_in.motor_speed);
    wait_mode(MSP_STAGE_HIZ, n);
    cmp("hold time", 1'b1, n >= 3 * TICK && n <= 4 * TICK + 2);
    repeat (20) @(negedge clk);
    cmp("stays off", MSP_STAGE_HIZ, so.stage_mode);
    go(16'h0032);
    bus(1'b1, MSP_CMD_OFS, 32'h1);
    repeat (2) @(negedge clk);
    cmp("direct brake", MSP_STAGE_LOWSIDE, so.stage_mode);
    wait_mode(MSP_STAGE_HIZ, n);
    bus(1'b1, MSP_CTRL_OFS, 32'h4);
    go(16'h03e8);
    halt();
    cmp("spin exit speed", 32'h12c, core_in.motor_speed);
    go(16'h03e8);
    @(posedge clk) brake_req <= 1'b1;
    wait_mode(MSP_STAGE_LOWSIDE, n);
    cmp("pin brake speed", 32'h64, core_in.motor_speed);
    repeat (100) @(negedge clk);
    cmp("pin brake held", MSP_STAGE_LOWSIDE, so.stage_mode);
    @(posedge clk) brake_req <= 1'b0;
    wait_mode(MSP_STAGE_HIZ, n);
  endtask : t_stops
  task automatic t_pulse;
    int n;
    int per;
    int divs [3] = '{1, 3, 15};
    bus(1'b1, MSP_CTRL_OFS, 32'h0);
    foreach (divs[i]) begin
      bus(1'b1, MSP_PULSE_OFS, 32'(divs[i]));
      go(16'h03e8);
      edges(50 * divs[i] + 50, n, per);
      cmp("pulse period", 32'(16 * divs[i]), 32'(per));
      halt();
    end
    bus(1'b1, MSP_CTRL_OFS, 32'h100);
    edges(40, n, per);
    cmp("idle high", 1'b1, spo);
    bus(1'b1, MSP_PULSE_OFS, 32'h00c8_0001);
    bus(1'b1, MSP_CTRL_OFS, 32'h8);
    go(16'h03e8);
    halt();
    edges(100, n, per);
    cmp("pulses while coasting", 1'b1, n > 1);
    spd(16'h0064);
    edges(100, n, per);
    cmp("pulses below floor", 32'h0, n);
    @(posedge clk) tb_core.fault_active <= 1'b1;
    bus(1'b1, MSP_CTRL_OFS, 32'h40);
    edges(20, n, per);
    cmp("fault high", 1'b1, spo);
    bus(1'b1, MSP_CTRL_OFS, 32'h0);
    @(posedge clk) tb_core.fault_active <= 1'b0;
    tb_core.closed_loop <= 1'b0;
    tb_core.open_loop <= 1'b1;
    bus(1'b1, MSP_CTRL_OFS, 32'h10);
    go(16'h03e8);
    edges(100, n, per);
    cmp("open loop held", 32'h1, {n[30:0], spo});
    halt();
    bus(1'b1, MSP_CTRL_OFS, 32'h0);
    go(16'h03e8);
    edges(100, n, per);
    cmp("open loop follows", 1'b1, n > 1);
    halt();
    bus(1'b1, MSP_CTRL_OFS, 32'h20);
    @(posedge clk) tb_core.wake_event <= 1'b1;
    @(posedge clk) tb_core.wake_event <= 1'b0;
    go(16'h03e8);
    edges(100, n, per);
    cmp("first start follows", 1'b1, n > 1);
    @(posedge clk) tb_core.closed_loop <= 1'b1;
    @(posedge clk) tb_core.closed_loop <= 1'b0;
    halt();
    go(16'h03e8);
    edges(100, n, per);
    cmp("later start held", 32'h1, {n[30:0], spo});
    halt();
  endtask : t_pulse
  task automatic est(input logic [15:0] e, input logic m, input logic f);
    @(posedge clk);
    tb_core.supply_current_est <= e;
    tb_core.speed_mode <= m;
    repeat (f ? 300 : 320) @(negedge clk);
    cmp("limit flag", f, flag);
  endtask : est
  task automatic t_limit;
    bus(1'b1, MSP_CAP_OFS, 32'h3e8);
    bus(1'b1, MSP_SETP_OFS, 32'h0320_07d0);
    bus(1'b1, MSP_CTRL_OFS, 32'h400);
    est(16'd1040, 1'b1, 1'b0);
    est(16'd1200, 1'b1, 1'b1);
    cmp("speed clamp", 1'b1, cst < 16'd2000);
    est(16'd980, 1'b1, 1'b1);
    est(16'd900, 1'b1, 1'b0);
    est(16'd1200, 1'b0, 1'b1);
    cmp("current clamp", 1'b1, cct < 16'd800);
    est(16'd900, 1'b0, 1'b0);
    bus(1'b1, MSP_CTRL_OFS, 32'hc00);
    est(16'd1200, 1'b1, 1'b0);
  endtask : t_limit
  initial begin
    srst = 1'b1;
    {adr, wd, rd, wr, spd_load, brake_req} = '0;
    tb_core = '0;
    tb_core.closed_loop = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_stops();
    t_pulse();
    t_limit();
    summarize();
  end
endmodule : test_motor_stop_speed_pulse_ctl
`default_nettype wire
